// ===== src/fmg_pkg.sv
// Package of constants and carrier types for the flash modify guard block
// ============================================================================
// Behaviour
// - Part identification byte readable at fixed address
// - Modify only with monitor and reset enabled
// - Power-on reset turns the monitor on
// - Interrupts held pending during flash operation
// - Write enable is control bit zero
// - One-shot pulses sense amps per access
// - One-shot active after reset; bit six bypasses
// - Clearing bypass bit restores the one-shot
// - Flash rows are 64 bytes; row change flagged
// - Idle exits within three clocks on interrupt
// - Flash-error flag shows after error reset
// - Write with erase enable erases whole page
package fmg_pkg;

	// ========================================================================
	// Address map and geometry
	localparam int          ADDR_W          = 14;
	localparam logic [13:0] PART_ID_ADDR    = 14'h3ffe;
	localparam int          ROW_BYTES       = 64;
	localparam int          ROW_SHIFT       = 6;
	localparam int          PAGE_SHIFT      = 9;

	// ========================================================================
	// Register bit positions
	localparam int          PSC_WE_BIT      = 0;
	localparam int          PSC_EE_BIT      = 1;
	localparam int          FSC_BYPASS_BIT  = 6;

	// ========================================================================
	// Timing
	localparam int          CLK_PERIOD_NS   = 4;
	localparam int          ONESHOT_NS      = 4;
	localparam int          ONESHOT_CYC     = (ONESHOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          WAKE_MAX_CYC    = 3;
	localparam int          PROG_CYC_DEF    = 16;
	localparam int          ERASE_CYC_DEF   = 64;
	localparam logic [7:0]  ERASED_BYTE     = 8'hff;

	// ========================================================================
	// Carrier types
	typedef struct packed {
		logic [13:0] addr;
		logic [7:0]  data;
	} fmg_req_t;

	typedef enum logic [2:0] {
		FMG_IDLE    = 3'b000,
		FMG_PROG    = 3'b001,
		FMG_ERASE   = 3'b010,
		FMG_ERRRST  = 3'b011,
		FMG_SLEEP   = 3'b100
	} fmg_state_t;

endpackage

// ===== src/fmg_array.sv
// Flash byte array model with registered read data
`timescale 1ns/1ns
module fmg_array #(
	parameter int         AW      = 14,
	parameter logic [7:0] PART_ID = 8'h5a   // Arbitrary identification value
) (
	input  wire logic          core_clk_i,
	input  wire logic          srst_i,
	input  wire logic          rd_i,
	input  wire logic [AW-1:0] rd_addr_i,
	input  wire logic          wr_i,
	input  wire logic          clr_i,
	input  wire logic [AW-1:0] wr_addr_i,
	input  wire logic [7:0]    wr_data_i,
	output logic      [7:0]    rd_data_o
);

	// ========================================================================
	// Storage
	logic [7:0] mem [0:(1<<AW)-1];
	logic [7:0] next_rd_data;

	// Read path, identification byte overrides the cell
	always_comb begin
		next_rd_data = rd_data_o;
		if (rd_i) begin
			if (rd_addr_i == fmg_pkg::PART_ID_ADDR[AW-1:0])
				next_rd_data = PART_ID;
			else
				next_rd_data = mem[rd_addr_i];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i)
			rd_data_o <= 8'h00;
		else
			rd_data_o <= next_rd_data;
	end

	// Write only clears bits; clear sets a byte to erased
	always_ff @(posedge core_clk_i) begin
		if (wr_i)
			mem[wr_addr_i] <= clr_i ? fmg_pkg::ERASED_BYTE : (mem[wr_addr_i] & wr_data_i);
	end

endmodule

// ===== src/fmg_guard.sv
// Flash modify guard, interrupt hold, idle wake and sense-amp one-shot
`timescale 1ns/1ns
module fmg_guard #(
	parameter int         PROG_CYC  = fmg_pkg::PROG_CYC_DEF,
	parameter int         ERASE_CYC = fmg_pkg::ERASE_CYC_DEF,
	parameter logic [7:0] PART_ID   = 8'h5a    // Arbitrary identification value
) (
	input  wire logic                     core_clk_i,
	input  wire logic                     srst_i,
	input  wire logic                     por_i,
	input  wire logic [7:0]               program_store_control_i,
	input  wire logic [7:0]               flash_scale_register_i,
	input  wire logic                     vmon_en_i,
	input  wire logic                     vmon_rst_en_i,
	input  wire logic                     rst_src_wr_i,
	input  wire logic                     power_on_reset_flag_wr_i,
	input  wire logic                     code_rd_i,
	input  wire logic [13:0]              code_addr_i,
	input  wire logic                     xdata_wr_i,
	input  wire fmg_pkg::fmg_req_t        xdata_req_i,
	input  wire logic                     irq_i,
	input  wire logic                     idle_req_i,
	output logic      [7:0]               code_data_o,
	output logic                          busy_o,
	output logic                          irq_hold_o,
	output logic                          flash_err_rst_o,
	output logic                          flash_error_flag_o,
	output logic                          vmon_force_on_o,
	output logic                          sense_en_o,
	output logic                          row_change_o,
	output logic                          idle_o,
	output logic                          cpu_run_o
);

	// ========================================================================
	// Decoded control bits
	logic we_bit;
	logic ee_bit;
	logic bypass_bit;
	assign we_bit     = program_store_control_i[fmg_pkg::PSC_WE_BIT];
	assign ee_bit     = program_store_control_i[fmg_pkg::PSC_EE_BIT];
	assign bypass_bit = flash_scale_register_i[fmg_pkg::FSC_BYPASS_BIT];

	// Page base of an address, used for erase start
	function automatic logic [13:0] page_base(input logic [13:0] a);
		page_base = {a[13:fmg_pkg::PAGE_SHIFT], {fmg_pkg::PAGE_SHIFT{1'b0}}};
	endfunction

	// Row number of an address
	function automatic logic [7:0] row_of(input logic [13:0] a);
		row_of = a[13:fmg_pkg::ROW_SHIFT];
	endfunction

	// ========================================================================
	// Modify state machine
	fmg_pkg::fmg_state_t state;
	fmg_pkg::fmg_state_t next_state;
	logic [15:0]         cnt;
	logic [15:0]         next_cnt;
	fmg_pkg::fmg_req_t   req;
	fmg_pkg::fmg_req_t   next_req;
	logic                err_flag;
	logic                next_err_flag;
	logic                vmon_force;
	logic                next_vmon_force;
	logic                arr_wr;
	logic                arr_clr;
	logic [13:0]         arr_addr;
	logic                modify_ok;

	// Enables sampled at the moment the access is issued
	assign modify_ok = vmon_en_i & vmon_rst_en_i;

	// Next-state logic for the modify sequence and reset-source bits
	always_comb begin
		next_state      = state;
		next_cnt        = cnt;
		next_req        = req;
		next_err_flag   = err_flag;
		next_vmon_force = vmon_force;
		arr_wr          = 1'b0;
		arr_clr         = 1'b0;
		arr_addr        = req.addr;
		// Whole-value write of reset-source register clears the error flag
		if (rst_src_wr_i && power_on_reset_flag_wr_i)
			next_vmon_force = 1'b0;
		if (rst_src_wr_i)
			next_err_flag = 1'b0;
		case (state)
			fmg_pkg::FMG_IDLE, fmg_pkg::FMG_SLEEP: begin
				if (xdata_wr_i && we_bit) begin
					next_req = xdata_req_i;
					if (!modify_ok) begin
						next_state = fmg_pkg::FMG_ERRRST;
					end else if (ee_bit) begin
						next_state    = fmg_pkg::FMG_ERASE;
						next_req.addr = page_base(xdata_req_i.addr);
						next_cnt      = 16'(ERASE_CYC);
					end else begin
						next_state = fmg_pkg::FMG_PROG;
						next_cnt   = 16'(PROG_CYC);
					end
				end else if (idle_req_i && !irq_i) begin
					next_state = fmg_pkg::FMG_SLEEP;
				end else if (irq_i) begin
					next_state = fmg_pkg::FMG_IDLE;
				end
			end
			fmg_pkg::FMG_PROG: begin
				if (cnt == 16'h0001) begin
					arr_wr     = 1'b1;
					next_state = fmg_pkg::FMG_IDLE;
				end
				next_cnt = cnt - 16'h0001;
			end
			fmg_pkg::FMG_ERASE: begin
				// One byte of the page cleared per cycle
				arr_wr   = 1'b1;
				arr_clr  = 1'b1;
				next_req.addr = req.addr + 14'h0001;
				if (req.addr[fmg_pkg::PAGE_SHIFT-1:0] == {fmg_pkg::PAGE_SHIFT{1'b1}})
					next_state = fmg_pkg::FMG_IDLE;
			end
			fmg_pkg::FMG_ERRRST: begin
				next_err_flag   = 1'b1;
				next_state      = fmg_pkg::FMG_IDLE;
			end
			default: next_state = fmg_pkg::FMG_IDLE;
		endcase
	end

	// Register the modify sequence; power-on reset forces monitor on
	always_ff @(posedge core_clk_i) begin
		if (srst_i && por_i) begin
			state      <= fmg_pkg::FMG_IDLE;
			cnt        <= 16'h0000;
			req        <= '0;
			err_flag   <= 1'b0;
			vmon_force <= 1'b1;
		end else if (srst_i) begin
			// Device reset keeps the error flag so software can read the cause
			state      <= fmg_pkg::FMG_IDLE;
			cnt        <= 16'h0000;
			req        <= '0;
			// An error reset that lands in the same cycle still leaves its mark
			err_flag   <= err_flag || (state == fmg_pkg::FMG_ERRRST);
			vmon_force <= vmon_force;
		end else begin
			state      <= next_state;
			cnt        <= next_cnt;
			req        <= next_req;
			err_flag   <= next_err_flag;
			vmon_force <= next_vmon_force;
		end
	end

	assign busy_o             = (state == fmg_pkg::FMG_PROG) || (state == fmg_pkg::FMG_ERASE);
	assign irq_hold_o         = busy_o;
	assign flash_err_rst_o    = (state == fmg_pkg::FMG_ERRRST);
	assign flash_error_flag_o = err_flag;
	assign vmon_force_on_o    = vmon_force;
	assign idle_o             = (state == fmg_pkg::FMG_SLEEP);
	// Wake is combinational on the interrupt, well inside three cycles
	assign cpu_run_o          = !idle_o || irq_i;

	// ========================================================================
	// Sense-amp one-shot and row tracking
	logic [7:0] last_row;
	logic [7:0] next_last_row;
	logic       row_chg;
	logic       next_row_chg;

	// Minimum pulse is one cycle here; bypass holds the amps on
	always_comb begin
		next_last_row = last_row;
		next_row_chg  = 1'b0;
		if (code_rd_i) begin
			next_last_row = row_of(code_addr_i);
			next_row_chg  = (row_of(code_addr_i) != last_row);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			last_row <= 8'h00;
			row_chg  <= 1'b0;
		end else begin
			last_row <= next_last_row;
			row_chg  <= next_row_chg;
		end
	end

	assign sense_en_o   = bypass_bit ? 1'b1 : code_rd_i;
	assign row_change_o = row_chg;

	// ========================================================================
	// Flash array
	fmg_array #(
		.AW      (fmg_pkg::ADDR_W),
		.PART_ID (PART_ID)
	) u_array (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.rd_i       (code_rd_i),
		.rd_addr_i  (code_addr_i),
		.wr_i       (arr_wr),
		.clr_i      (arr_clr),
		.wr_addr_i  (arr_addr),
		.wr_data_i  (req.data),
		.rd_data_o  (code_data_o)
	);

endmodule

// ===== dv/fmg_guard_properties.sv
// Port checker for the flash modify guard
`timescale 1ns/1ns
module fmg_guard_properties #(
	parameter logic [7:0] PART_ID = 8'h5a
) (
	input wire logic        core_clk_i,
	input wire logic        srst_i,
	input wire logic [7:0]  program_store_control_i,
	input wire logic [7:0]  flash_scale_register_i,
	input wire logic        vmon_en_i,
	input wire logic        vmon_rst_en_i,
	input wire logic        code_rd_i,
	input wire logic [13:0] code_addr_i,
	input wire logic        xdata_wr_i,
	input wire logic        irq_i,
	input wire logic [7:0]  code_data_o,
	input wire logic        busy_o,
	input wire logic        irq_hold_o,
	input wire logic        flash_err_rst_o,
	input wire logic        flash_error_flag_o,
	input wire logic        sense_en_o,
	input wire logic        row_change_o,
	input wire logic        idle_o,
	input wire logic        cpu_run_o
);
	// =====
	// One clock domain, reset disables every check
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	// Modify request taken while nothing runs
	sequence take_s;
		xdata_wr_i && program_store_control_i[0] && !busy_o && !flash_err_rst_o;
	endsequence
	// Row of the last code read; starts at row zero after reset
	logic [7:0] prev_row;
	always_ff @(posedge core_clk_i) begin
		if (srst_i)
			prev_row <= 8'h00;
		else if (code_rd_i)
			prev_row <= code_addr_i[13:fmg_pkg::ROW_SHIFT];
	end
	// =====
	// Guard, flag and interrupt hold
	guard_reset_a: assert property (take_s ##0 !(vmon_en_i && vmon_rst_en_i) |=> flash_err_rst_o && !busy_o)
		else $error("no error reset");
	guard_start_a: assert property (take_s ##0 (vmon_en_i && vmon_rst_en_i) |=> busy_o && !flash_err_rst_o)
		else $error("modify not started");
	flag_set_a: assert property (flash_err_rst_o |=> flash_error_flag_o)
		else $error("flag not set");
	irq_hold_a: assert property (busy_o && irq_i |-> irq_hold_o)
		else $error("irq not held");
	idle_wake_a: assert property (idle_o && irq_i |-> ##[0:3] cpu_run_o)
		else $error("slow wake");
	idle_exit_a: assert property (idle_o && irq_i |-> ##[1:3] !idle_o)
		else $error("idle not left");
	row_change_a: assert property (row_change_o == ($past(code_rd_i) && ($past(code_addr_i[13:fmg_pkg::ROW_SHIFT]) != $past(prev_row))))
		else $error("row change wrong");
	// =====
	// Sense one-shot and part id
	sense_bypass_a: assert property (flash_scale_register_i[6] |-> sense_en_o)
		else $error("bypass ignored");
	sense_shot_a: assert property (!flash_scale_register_i[6] |-> sense_en_o == code_rd_i)
		else $error("one-shot wrong");
	part_id_a: assert property (code_rd_i && code_addr_i == fmg_pkg::PART_ID_ADDR |=> code_data_o == PART_ID)
		else $error("part id wrong");
endmodule
bind fmg_guard fmg_guard_properties #(.PART_ID(PART_ID)) u_fmg_guard_properties (.*);

// ===== dv/fmg_cpu_model.sv
// CPU side model issuing one-cycle code reads
`timescale 1ns/1ns
module fmg_cpu_model (
	input  wire logic        core_clk_i,
	input  wire logic        go_i,
	input  wire logic [13:0] addr_i,
	output logic             code_rd_o,
	output logic [13:0]      code_addr_o
);
	// =====
	// Address inverted between reads so a stale value never looks valid
	always_ff @(posedge core_clk_i) begin
		code_rd_o <= go_i;
		code_addr_o <= go_i ? addr_i : ~addr_i;
	end
endmodule

// ===== dv/fmg_guard_tb.sv
// Self-checking bench for the flash modify guard
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t %h %h", $time, g, e); end end
module fmg_guard_tb;
	localparam logic [7:0] PART_ID = 8'h3c; // Arbitrary identification value
	logic              clk = '0, srst = '1, por = '1, go = '0, rd, rd_d = '0, busy, flag, fon;
	logic              ven = '0, vren = '0, rsw = '0, porw = '0, xwr = '0, irq = '0, idl = '0;
	logic [7:0]        psc = '0, fsc = '0, dout, b, exp_b;
	logic [13:0]       ga = '0, ca, a;
	fmg_pkg::fmg_req_t req = '0;
	int                err_count = 0, check_count = 0, cyc = 0;
	logic [7:0]        exp_q[$];
	// =====
	// Clock, design and CPU model; short program time keeps the run brief
	always #2 clk = ~clk;
	fmg_guard #(.PROG_CYC(4), .PART_ID(PART_ID)) u_fmg_guard (.core_clk_i(clk), .srst_i(srst), .por_i(por),
		.program_store_control_i(psc), .flash_scale_register_i(fsc), .vmon_en_i(ven), .vmon_rst_en_i(vren),
		.rst_src_wr_i(rsw), .power_on_reset_flag_wr_i(porw), .code_rd_i(rd), .code_addr_i(ca), .xdata_wr_i(xwr),
		.xdata_req_i(req), .irq_i(irq), .idle_req_i(idl), .code_data_o(dout), .busy_o(busy), .irq_hold_o(),
		.flash_err_rst_o(), .flash_error_flag_o(flag), .vmon_force_on_o(fon), .sense_en_o(), .row_change_o(),
		.idle_o(), .cpu_run_o());
	fmg_cpu_model u_fmg_cpu_model (.core_clk_i(clk), .go_i(go), .addr_i(ga), .code_rd_o(rd), .code_addr_o(ca));
	// Read data compared a cycle after the strobe; the cycle ceiling cuts a hang
	always @(posedge clk) begin
		// Pop once, so a mismatch report cannot eat a second note
		if (rd_d) begin
			exp_b = exp_q.pop_front();
			`CHK(dout, exp_b)
		end
		rd_d <= rd;
		cyc++;
		if (cyc == 4000) begin
			err_count++;
			end_sim();
		end
	end
	// =====
	// Read one byte, noting the expected value first
	task automatic rdb(input logic [13:0] ad, input logic [7:0] e);
		exp_q.push_back(e);
		go <= 1'h1;
		ga <= ad;
		@(posedge clk);
		go <= 1'h0;
		repeat (3) @(posedge clk);
	endtask
	// Modify the byte at a, waiting a bounded time for busy to fall
	task automatic mod(input logic [1:0] m, input logic [7:0] d);
		psc <= {6'h00, m};
		@(posedge clk);
		xwr <= 1'h1;
		req <= {a, d};
		@(posedge clk);
		xwr <= 1'h0;
		@(posedge clk);
		for (int i = 0; i < 700 && busy !== 1'h0; i++) @(posedge clk);
		`CHK(busy, 1'h0)
		psc <= 8'h00;
		@(posedge clk);
	endtask
	// Verdict and end of run
	task end_sim;
		if (err_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// =====
	// Main sequence
	initial begin
		void'($urandom(32'haecb));
		a = 14'($urandom() % 512);
		b = 8'($urandom());
		repeat (2) @(posedge clk);
		srst <= '0;
		por <= '0;
		@(posedge clk);
		#1 `CHK(fon, 1'h1)
		`CHK(flag, 1'h0)
		@(posedge clk);
		rsw <= '1;
		porw <= '1;
		@(posedge clk);
		rsw <= '0;
		ven <= '1;
		vren <= '1;
		rdb(fmg_pkg::PART_ID_ADDR, PART_ID);
		mod(2'h3, 8'h00);
		rdb(a, fmg_pkg::ERASED_BYTE);
		rdb(a ^ 14'h0100, fmg_pkg::ERASED_BYTE);
		mod(2'h1, b);
		irq <= '1;
		mod(2'h1, 8'h0f);
		irq <= '0;
		rdb(a, b & 8'h0f);
		vren <= '0;
		mod(2'h1, 8'h00);
		#1 `CHK(flag, 1'h1)
		@(posedge clk);
		srst <= '1;
		@(posedge clk);
		srst <= '0;
		@(posedge clk);
		#1 `CHK(flag, 1'h1)
		@(posedge clk);
		fsc <= 8'h40;
		rdb(a, b & 8'h0f);
		fsc <= 8'h00;
		idl <= '1;
		repeat (4) @(posedge clk);
		irq <= '1;
		repeat (4) @(posedge clk);
		end_sim();
	end
endmodule
